//--- inc/nhs_pkg.sv
// constants shared by both ends of the oscillator bank link
// assumes both ends run on pclk at 40 MHz
package nhs_pkg;

    localparam int NHS_CHANNELS    = 2;
    localparam int NHS_OSCS        = 4;
    localparam int NHS_SAMPLE_W    = 12;
    localparam int NHS_MIX_W       = 13;
    localparam int NHS_RDIV_W      = 16;
    localparam int NHS_RCNT_W      = 22;
    localparam int NHS_RDIV_SHIFT  = 6;

    // cycle counts: selector path 2 sync + pipe + output = 45, sample path pipe + output = 37
    localparam int NHS_SEL_PIPE    = 42;
    localparam int NHS_SAMPLE_PIPE = 36;

    // device config space, word addresses on the config port
    localparam logic [7:0] NHS_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] NHS_ADDR_SELECT = 8'h01;
    localparam logic [7:0] NHS_ADDR_RDIV   = 8'h02;
    localparam logic [7:0] NHS_ADDR_FREQ   = 8'h10;
    localparam logic [7:0] NHS_ADDR_PHASE  = 8'h20;
    localparam logic [7:0] NHS_ADDR_GMASK  = 8'hF8;

    // ctrl field positions
    localparam int NHS_CTRL_SRC_BIT   = 0;
    localparam int NHS_CTRL_LINK_BIT  = 1;
    localparam int NHS_CTRL_ARM_BIT   = 2;
    localparam int NHS_CTRL_EN_BIT    = 3;
    localparam int NHS_ADDR_CHAN_BIT  = 2;

    // host APB byte offsets
    localparam logic [7:0] NHS_HOST_CFG_ADDR = 8'h00;
    localparam logic [7:0] NHS_HOST_CFG_DATA = 8'h04;
    localparam logic [7:0] NHS_HOST_LINK     = 8'h08;
    localparam logic [7:0] NHS_HOST_STATUS   = 8'h0C;

    // host link register fields and reset value (sync deasserted high)
    localparam int NHS_LINK_SYNC_BIT     = 0;
    localparam int NHS_LINK_SYSREF_BIT   = 1;
    localparam int NHS_LINK_HOP_LSB      = 2;
    localparam logic [5:0] NHS_LINK_RESET = 6'h01;

endpackage

//--- inc/nhs_link_if.sv
// link between the oscillator bank and its receiver/config host
// assumes the bench resolves nothing: all signals are one-way
`timescale 1ns/1ps
`default_nettype none
interface nhs_link_if;
    // config write port
    logic        cfg_wr;
    logic [7:0]  cfg_addr;
    logic [31:0] cfg_wdata;
    // link start signal, high means deasserted
    logic        link_sync;
    logic        sysref;
    // hop selection pins
    logic        chan_a_hop_pin_lsb;
    logic        chan_a_hop_pin_msb;
    logic        chan_b_hop_pin_lsb;
    logic        chan_b_hop_pin_msb;
    // alignment event back to the host
    logic        align_pulse;

    modport dev (
        input  cfg_wr, cfg_addr, cfg_wdata, link_sync, sysref,
        input  chan_a_hop_pin_lsb, chan_a_hop_pin_msb,
        input  chan_b_hop_pin_lsb, chan_b_hop_pin_msb,
        output align_pulse
    );
    modport host (
        output cfg_wr, cfg_addr, cfg_wdata, link_sync, sysref,
        output chan_a_hop_pin_lsb, chan_a_hop_pin_msb,
        output chan_b_hop_pin_lsb, chan_b_hop_pin_msb,
        input  align_pulse
    );
endinterface
`default_nettype wire

//--- src/nhs_host.sv
// host end: APB register slave that drives config writes and link pins
// assumes the device end sits across nhs_link_if on the same pclk
`timescale 1ns/1ps
`default_nettype none
module nhs_host (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // link to device
    nhs_link_if.host         link
);

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [7:0]  cfg_addr_reg;
        logic        cfg_wr;
        logic [7:0]  cfg_addr;
        logic [31:0] cfg_wdata;
        logic [5:0]  link_reg;
        logic [15:0] align_count;
    } nhs_host_s;

    nhs_host_s st_reg;
    nhs_host_s st_next;

    always_comb begin
        logic setup;
        logic access;
        logic mapped;
        setup   = psel && !penable;
        access  = psel && penable && st_reg.pready;
        mapped  = (paddr == nhs_pkg::NHS_HOST_CFG_ADDR) || (paddr == nhs_pkg::NHS_HOST_CFG_DATA)
               || (paddr == nhs_pkg::NHS_HOST_LINK) || (paddr == nhs_pkg::NHS_HOST_STATUS);
        st_next = st_reg;
        st_next.cfg_wr = 1'b0;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (link.align_pulse) begin
            st_next.align_count = st_reg.align_count + 16'h0001;
        end
        // answer is prepared in setup and shown for the single access cycle
        if (setup) begin
            st_next.pready  = 1'b1;
            st_next.pslverr = !mapped;
            case (paddr)
                nhs_pkg::NHS_HOST_CFG_ADDR: st_next.prdata = {24'h000000, st_reg.cfg_addr_reg};
                nhs_pkg::NHS_HOST_LINK:     st_next.prdata = {26'h0000000, st_reg.link_reg};
                nhs_pkg::NHS_HOST_STATUS:   st_next.prdata = {16'h0000, st_reg.align_count};
                default:                    st_next.prdata = 32'h00000000;
            endcase
        end
        if (access && pwrite && mapped) begin
            case (paddr)
                nhs_pkg::NHS_HOST_CFG_ADDR: st_next.cfg_addr_reg = pwdata[7:0];
                nhs_pkg::NHS_HOST_CFG_DATA: begin
                    // writing the data word issues one config write to the device
                    st_next.cfg_wr    = 1'b1;
                    st_next.cfg_addr  = st_reg.cfg_addr_reg;
                    st_next.cfg_wdata = pwdata;
                end
                nhs_pkg::NHS_HOST_LINK:     st_next.link_reg = pwdata[5:0];
                default:                    st_next.link_reg = st_reg.link_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            st_reg.link_reg <= nhs_pkg::NHS_LINK_RESET;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign prdata                  = st_reg.prdata;
    assign pready                  = st_reg.pready;
    assign pslverr                 = st_reg.pslverr;
    assign link.cfg_wr             = st_reg.cfg_wr;
    assign link.cfg_addr           = st_reg.cfg_addr;
    assign link.cfg_wdata          = st_reg.cfg_wdata;
    assign link.link_sync          = st_reg.link_reg[nhs_pkg::NHS_LINK_SYNC_BIT];
    assign link.sysref             = st_reg.link_reg[nhs_pkg::NHS_LINK_SYSREF_BIT];
    assign link.chan_a_hop_pin_lsb = st_reg.link_reg[nhs_pkg::NHS_LINK_HOP_LSB];
    assign link.chan_a_hop_pin_msb = st_reg.link_reg[nhs_pkg::NHS_LINK_HOP_LSB + 1];
    assign link.chan_b_hop_pin_lsb = st_reg.link_reg[nhs_pkg::NHS_LINK_HOP_LSB + 2];
    assign link.chan_b_hop_pin_msb = st_reg.link_reg[nhs_pkg::NHS_LINK_HOP_LSB + 3];

endmodule
`default_nettype wire

//--- src/nhs_device.sv
// device end: two channels of four phase accumulators with hop select and alignment
// assumes link pins are asynchronous; config writes come from logic on pclk
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - four oscillators per channel, separately programmable
// - all accumulators advance every clock
// - pin selection follows asynchronous pin changes
// - pins to mixer ~45, sample ~37 cycles
// - source bit 1: pins select, field ignored
// - source bit 0 at reset: field selects
// - selector is binary index, msb first
// - frequency and phase word per accumulator
// - divider zero: add 32-bit word each clock
// - frequency word is a modulo increment
// - frequency rewrite needs later alignment event
// - nonzero divider: exact multiples of step
// - software keeps divider at most 8192
// - phase offset in upper half, added
// - realign on link sync or sysref
// - sync deassertion high realigns all oscillators
// - sync low arms, later rise aligns
// - dc sysref: arm then single pulse
// - arm write lands between sysref edges
// - first sysref rise after arming aligns
// - oscillator output multiplies the real sample
module nhs_device (
    // clock, reset, enable
    input  wire logic                                         pclk,
    input  wire logic                                         presetn,
    input  wire logic                                         ce,
    // link and config from host
    nhs_link_if.dev                                           link,
    // converter samples, one per channel
    input  wire logic [1:0][nhs_pkg::NHS_SAMPLE_W-1:0]        adc_sample,
    // mixer results and selected phase per channel
    output logic      [1:0][nhs_pkg::NHS_MIX_W-1:0]           mix_i,
    output logic      [1:0][nhs_pkg::NHS_MIX_W-1:0]           mix_q,
    output logic      [1:0][31:0]                             nco_phase,
    output logic      [1:0][1:0]                              active_osc
);

    typedef struct packed {
        // pin synchronisers: hop pins, link sync, sysref
        logic [5:0]                                          pin_s1;
        logic [5:0]                                          pin_s2;
        logic                                                sync_prev;
        logic                                                sysref_prev;
        // config
        logic                                                osc_select_source;
        logic                                                link_start_align_enable;
        logic                                                sysref_align_arm;
        logic                                                link_enable;
        logic [1:0][1:0]                                     sel_field;
        logic [nhs_pkg::NHS_RDIV_W-1:0]                      rational_step_divider;
        logic [1:0][3:0][31:0]                               freq_word;
        logic [1:0][3:0][15:0]                               phase_offset;
        // oscillator state
        logic [1:0][3:0][31:0]                               acc;
        logic [nhs_pkg::NHS_RCNT_W-1:0]                      rdiv_cnt;
        logic                                                sync_armed;
        // latency pipes
        logic [1:0][nhs_pkg::NHS_SEL_PIPE-1:0][1:0]          sel_pipe;
        logic [1:0][nhs_pkg::NHS_SAMPLE_PIPE-1:0][nhs_pkg::NHS_SAMPLE_W-1:0] sample_pipe;
        // outputs
        logic [1:0][nhs_pkg::NHS_MIX_W-1:0]                  mix_i;
        logic [1:0][nhs_pkg::NHS_MIX_W-1:0]                  mix_q;
        logic [1:0][31:0]                                    nco_phase;
        logic [1:0][1:0]                                     active_osc;
        logic                                                align_pulse;
    } nhs_dev_s;

    nhs_dev_s st_reg;
    nhs_dev_s st_next;

    logic [5:0] pins_raw;

    assign pins_raw = {link.sysref, link.link_sync,
                       link.chan_b_hop_pin_msb, link.chan_b_hop_pin_lsb,
                       link.chan_a_hop_pin_msb, link.chan_a_hop_pin_lsb};

    always_comb begin
        logic                               sync_now;
        logic                               sysref_now;
        logic                               sync_rise;
        logic                               sync_fall;
        logic                               sysref_rise;
        logic                               link_mode;
        logic                               align;
        logic                               rdiv_wrap;
        logic [nhs_pkg::NHS_RCNT_W-1:0]     rdiv_last;
        logic [1:0]                         sel_src;
        logic [1:0]                         sel_out;
        logic [31:0]                        ph;
        logic signed [nhs_pkg::NHS_MIX_W-1:0] smp;
        logic [7:0]                         wa;
        sync_now    = 1'b0;
        sysref_now  = 1'b0;
        sync_rise   = 1'b0;
        sync_fall   = 1'b0;
        sysref_rise = 1'b0;
        link_mode   = 1'b0;
        align       = 1'b0;
        rdiv_wrap   = 1'b0;
        rdiv_last   = '0;
        sel_src     = 2'h0;
        sel_out     = 2'h0;
        ph          = 32'h00000000;
        smp         = '0;
        wa          = link.cfg_addr;
        st_next     = st_reg;

        // two flops before anything looks at a pin
        st_next.pin_s1 = pins_raw;
        st_next.pin_s2 = st_reg.pin_s1;
        sync_now       = st_reg.pin_s2[4];
        sysref_now     = st_reg.pin_s2[5];
        st_next.sync_prev   = sync_now;
        st_next.sysref_prev = sysref_now;
        sync_rise   = sync_now && !st_reg.sync_prev;
        sync_fall   = !sync_now && st_reg.sync_prev;
        sysref_rise = sysref_now && !st_reg.sysref_prev;

        // link-sync alignment: fall arms, rise aligns, only while link start align and link enable are both set
        link_mode = st_reg.link_start_align_enable && st_reg.link_enable;
        if (link_mode && sync_fall) begin
            st_next.sync_armed = 1'b1;
        end
        if (link_mode && sync_rise && st_reg.sync_armed) begin
            align              = 1'b1;
            st_next.sync_armed = 1'b0;
        end
        if (!link_mode) begin
            st_next.sync_armed = 1'b0;
        end

        // sysref alignment consumes the arm bit
        if (st_reg.sysref_align_arm && sysref_rise) begin
            align                    = 1'b1;
            st_next.sysref_align_arm = 1'b0;
        end

        // rational mode: after 64*divider clocks an integer multiple of the step
        // has accumulated whole cycles, so the phase lands exactly on zero
        rdiv_last = nhs_pkg::NHS_RCNT_W'({st_reg.rational_step_divider,
                    {nhs_pkg::NHS_RDIV_SHIFT{1'b0}}} - 1);
        rdiv_wrap = (st_reg.rational_step_divider != '0) && (st_reg.rdiv_cnt == rdiv_last);
        if (align || rdiv_wrap || (st_reg.rational_step_divider == '0)) begin
            st_next.rdiv_cnt = '0;
        end else begin
            st_next.rdiv_cnt = st_reg.rdiv_cnt + 1'b1;
        end

        for (int c = 0; c < nhs_pkg::NHS_CHANNELS; c++) begin
            for (int x = 0; x < nhs_pkg::NHS_OSCS; x++) begin
                if (align || rdiv_wrap) begin
                    st_next.acc[c][x] = 32'h00000000;
                end else begin
                    // unselected oscillators keep running; wraps modulo 2^32
                    st_next.acc[c][x] = st_reg.acc[c][x] + st_reg.freq_word[c][x];
                end
            end

            // selector source, then the hop latency pipe
            if (st_reg.osc_select_source) begin
                sel_src = {st_reg.pin_s2[2 * c + 1], st_reg.pin_s2[2 * c]};
            end else begin
                sel_src = st_reg.sel_field[c];
            end
            st_next.sel_pipe[c] = {st_reg.sel_pipe[c][nhs_pkg::NHS_SEL_PIPE-2:0], sel_src};
            st_next.sample_pipe[c] = {st_reg.sample_pipe[c][nhs_pkg::NHS_SAMPLE_PIPE-2:0],
                                      adc_sample[c]};
            sel_out = st_reg.sel_pipe[c][nhs_pkg::NHS_SEL_PIPE-1];

            // offset sits in the upper half of the phase word
            ph  = st_reg.acc[c][sel_out] + {st_reg.phase_offset[c][sel_out], 16'h0000};
            smp = nhs_pkg::NHS_MIX_W'($signed(st_reg.sample_pipe[c][nhs_pkg::NHS_SAMPLE_PIPE-1]));
            st_next.active_osc[c] = sel_out;
            st_next.nco_phase[c]  = ph;

            // quadrant-resolution exponential: cheap, but only a coarse carrier
            case (ph[31:30])
                2'h0: begin
                    st_next.mix_i[c] = smp;
                    st_next.mix_q[c] = '0;
                end
                2'h1: begin
                    st_next.mix_i[c] = '0;
                    st_next.mix_q[c] = smp;
                end
                2'h2: begin
                    st_next.mix_i[c] = -smp;
                    st_next.mix_q[c] = '0;
                end
                default: begin
                    st_next.mix_i[c] = '0;
                    st_next.mix_q[c] = -smp;
                end
            endcase
        end

        // config writes; an arm write in the alignment cycle wins over the clear
        if (link.cfg_wr) begin
            case (wa & nhs_pkg::NHS_ADDR_GMASK)
                nhs_pkg::NHS_ADDR_CTRL: begin
                    if (wa == nhs_pkg::NHS_ADDR_CTRL) begin
                        st_next.osc_select_source       =
                            link.cfg_wdata[nhs_pkg::NHS_CTRL_SRC_BIT];
                        st_next.link_start_align_enable =
                            link.cfg_wdata[nhs_pkg::NHS_CTRL_LINK_BIT];
                        st_next.sysref_align_arm        =
                            link.cfg_wdata[nhs_pkg::NHS_CTRL_ARM_BIT];
                        st_next.link_enable             =
                            link.cfg_wdata[nhs_pkg::NHS_CTRL_EN_BIT];
                    end else if (wa == nhs_pkg::NHS_ADDR_SELECT) begin
                        st_next.sel_field[0] = link.cfg_wdata[1:0];
                        st_next.sel_field[1] = link.cfg_wdata[3:2];
                    end else if (wa == nhs_pkg::NHS_ADDR_RDIV) begin
                        st_next.rational_step_divider =
                            link.cfg_wdata[nhs_pkg::NHS_RDIV_W-1:0];
                    end
                end
                nhs_pkg::NHS_ADDR_FREQ: begin
                    // running phase goes non-deterministic until the next alignment
                    st_next.freq_word[wa[nhs_pkg::NHS_ADDR_CHAN_BIT]][wa[1:0]] =
                        link.cfg_wdata;
                end
                nhs_pkg::NHS_ADDR_PHASE: begin
                    st_next.phase_offset[wa[nhs_pkg::NHS_ADDR_CHAN_BIT]][wa[1:0]] =
                        link.cfg_wdata[15:0];
                end
                default: begin
                    st_next.link_enable = st_reg.link_enable;
                end
            endcase
        end

        st_next.align_pulse = align;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            // sync pin idles high: no false edge
            st_reg.pin_s1[4] <= 1'b1;
            st_reg.pin_s2[4] <= 1'b1;
            st_reg.sync_prev <= 1'b1;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign mix_i            = st_reg.mix_i;
    assign mix_q            = st_reg.mix_q;
    assign nco_phase        = st_reg.nco_phase;
    assign active_osc       = st_reg.active_osc;
    assign link.align_pulse = st_reg.align_pulse;

endmodule
`default_nettype wire

//--- tb/nhs_link_properties.sv
// checker for the link between the oscillator bank and its host
// assumes it watches the nhs_link_if signals on pclk
`timescale 1ns/1ps
`default_nettype none
module nhs_link_properties (
    // clock, reset
    input wire logic        pclk,
    input wire logic        presetn,
    // link
    input wire logic        cfg_wr,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic        link_sync,
    input wire logic        sysref,
    input wire logic        align_pulse
);
    logic mode_reg, sync_arm_reg, sys_arm_reg, sync_q, sys_q;
    wire sys_rise = sysref & ~sys_q;
    wire sync_rise = link_sync & ~sync_q;
    wire sync_fall = ~link_sync & sync_q;
    wire ctrl_wr = cfg_wr && cfg_addr == nhs_pkg::NHS_ADDR_CTRL;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // arm mirror; only exact if arm writes stay clear of edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_reg, sync_arm_reg, sys_arm_reg, sys_q} <= 4'h0;
            sync_q <= 1'h1;
        end else begin
            sync_q <= link_sync;
            sys_q <= sysref;
            if (ctrl_wr) begin
                mode_reg <= cfg_wdata[1] & cfg_wdata[3];
                sys_arm_reg <= cfg_wdata[2];
            end else if (sys_rise) begin
                sys_arm_reg <= 1'h0;
            end
            sync_arm_reg <= mode_reg & (sync_fall | (sync_arm_reg & ~sync_rise));
        end
    end
    property p_sysref_align; sys_rise && sys_arm_reg |-> ##3 align_pulse; endproperty
    a_sysref_align: assert property (p_sysref_align) else $error("armed sysref missed");
    property p_sync_align; sync_rise && sync_arm_reg |-> ##3 align_pulse; endproperty
    a_sync_align: assert property (p_sync_align) else $error("sync rise missed");
    property p_fall_arms; sync_fall && !sys_rise |-> ##3 !align_pulse; endproperty
    a_fall_arms: assert property (p_fall_arms) else $error("sync fall aligned");
    property p_disarmed; sys_rise && !sys_arm_reg && !sync_rise |-> ##3 !align_pulse; endproperty
    a_disarmed: assert property (p_disarmed) else $error("unarmed sysref aligned");
    property p_cause; align_pulse |-> $past(sys_rise, 3) || $past(sync_rise, 3); endproperty
    a_cause: assert property (p_cause) else $error("alignment without cause");
    property p_once; align_pulse |=> !align_pulse; endproperty
    a_once: assert property (p_once) else $error("alignment pulse too long");
    property p_cfg_pulse; cfg_wr |=> !cfg_wr; endproperty
    a_cfg_pulse: assert property (p_cfg_pulse) else $error("config write doubled");
    property p_sync_idle; $rose(presetn) |-> link_sync; endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("sync low after reset");
    c_sysref: cover property (sys_rise && sys_arm_reg);
    c_sync: cover property (sync_rise && sync_arm_reg);
    c_disarmed: cover property (sys_rise && !sys_arm_reg);
endmodule
`default_nettype wire

//--- tb/test_nco_hop_select_and_sync.sv
// testbench: host and device ends joined by nhs_link_if, driven over APB
// assumes 0 wait-state APB and fixed 45/37 cycle selector and sample paths
`timescale 1ns/1ps
`default_nettype none
module test_nco_hop_select_and_sync;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chk;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, prev_ph;
    logic [1:0][11:0] adc;
    logic [1:0][12:0] mix_i, mix_q;
    logic [1:0][31:0] nco_phase;
    logic [1:0][1:0] active_osc;
    int num_errors, comparisons;
    logic [32:0] rdq[$];
    logic [35:0] stq[$];
    string nm[7] = '{"act_a", "act_b", "phase_a", "mix_i_a", "mix_q_a", "step_a", "rdiv_a"};
    nhs_link_if link_bus ();
    nhs_host i_nhs_host (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_bus.host));
    nhs_device i_nhs_device (.pclk(pclk), .presetn(presetn), .ce(1'h1),
        .link(link_bus.dev), .adc_sample(adc), .mix_i(mix_i), .mix_q(mix_q),
        .nco_phase(nco_phase), .active_osc(active_osc));
    nhs_link_properties i_nhs_link_properties (.pclk(pclk), .presetn(presetn),
        .cfg_wr(link_bus.cfg_wr), .cfg_addr(link_bus.cfg_addr),
        .cfg_wdata(link_bus.cfg_wdata), .link_sync(link_bus.link_sync),
        .sysref(link_bus.sysref), .align_pulse(link_bus.align_pulse));
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] obs(logic [3:0] k);
        case (k)
            4'h0: obs = {30'h0, active_osc[0]};
            4'h1: obs = {30'h0, active_osc[1]};
            4'h2: obs = nco_phase[0];
            4'h3: obs = 32'($signed(mix_i[0]));
            4'h4: obs = 32'($signed(mix_q[0]));
            4'h5: obs = nco_phase[0] - prev_ph;
            default: obs = {31'h0, nco_phase[0] < 32'h82};
        endcase
    endfunction
    // notes are taken off the queues when the answer shows
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            cmp("prdata", rdq[0][31:0], prdata);
            cmp("pslverr", {31'h0, rdq[0][32]}, {31'h0, pslverr});
            void'(rdq.pop_front());
        end
        if (chk) begin
            cmp(nm[stq[0][35:32]], stq[0][31:0], obs(stq[0][35:32]));
            void'(stq.pop_front());
        end
        prev_ph = nco_phase[0];
    end
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
        int n;
        n = 0;
        if (!w) rdq.push_back(e);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            num_errors++;
            give_verdict();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'h1, a, d, 33'h0);
    endtask
    task automatic rd(logic [7:0] a, logic [32:0] e);
        apb(1'h0, a, 32'h0, e);
    endtask
    task automatic cfg(logic [7:0] a, logic [31:0] d);
        wr(nhs_pkg::NHS_HOST_CFG_ADDR, {24'h0, a});
        wr(nhs_pkg::NHS_HOST_CFG_DATA, d);
    endtask
    task automatic chkv(logic [3:0] k, logic [31:0] e);
        stq.push_back({k, e});
        chk <= 1'h1;
        @(posedge pclk);
        chk <= 1'h0;
        @(posedge pclk);
    endtask
    // pin write keeps sync deasserted
    task automatic hop(int a, int b);
        wr(nhs_pkg::NHS_HOST_LINK, 32'(1 + a * 4 + b * 16));
    endtask
    initial begin
        logic [11:0] s;
        logic [31:0] f [3];
        int k;
        {presetn, psel, penable, pwrite, chk} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        adc = 24'h0;
        void'($urandom(32'hAC62CCA5));
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(nhs_pkg::NHS_HOST_LINK, 33'h1);
        rd(nhs_pkg::NHS_HOST_STATUS, 33'h0);
        rd(8'h10, 33'h1_0000_0000);
        for (k = 0; k < 4; k++) cfg(nhs_pkg::NHS_ADDR_PHASE + 8'(k), 32'(k) << 14);
        for (k = 0; k < 4; k++) begin
            s = 12'($urandom);
            adc <= {12'($urandom), s};
            hop(3 - k, k);
            cfg(nhs_pkg::NHS_ADDR_SELECT, 32'((3 - k) * 4 + k));
            repeat (50) @(posedge pclk);
            chkv(4'h0, 32'(k));
            chkv(4'h1, 32'(3 - k));
            chkv(4'h2, 32'(k) << 30);
            chkv(4'h3, k == 0 ? 32'($signed(s)) : k == 2 ? -32'($signed(s)) : 32'h0);
            chkv(4'h4, k == 1 ? 32'($signed(s)) : k == 3 ? -32'($signed(s)) : 32'h0);
        end
        cfg(nhs_pkg::NHS_ADDR_CTRL, 32'h1);
        hop(0, 3);
        repeat (60) @(posedge pclk);
        for (k = 0; k < 4; k++) begin
            hop((k + 1) % 4, 3 - k);
            repeat (38) @(posedge pclk);
            chkv(4'h0, 32'(k));
            repeat (8) @(posedge pclk);
            chkv(4'h0, 32'((k + 1) % 4));
            chkv(4'h1, 32'(3 - k));
        end
        cfg(nhs_pkg::NHS_ADDR_CTRL, 32'h0);
        cfg(nhs_pkg::NHS_ADDR_SELECT, 32'h1);
        f = '{$urandom, 32'hFFFF_FFFF, 32'h8000_0000};
        for (k = 0; k < 3; k++) begin
            cfg(nhs_pkg::NHS_ADDR_FREQ + 8'h1, f[k]);
            repeat (50) @(posedge pclk);
            chkv(4'h5, f[k]);
        end
        // divider 1 wraps every 64 cycles, so a step of 2 never passes 0x82
        cfg(nhs_pkg::NHS_ADDR_RDIV, 32'h1);
        cfg(nhs_pkg::NHS_ADDR_SELECT, 32'h0);
        cfg(nhs_pkg::NHS_ADDR_FREQ, 32'h2);
        repeat (50) @(posedge pclk);
        for (k = 0; k < 100; k++) chkv(4'h6, 32'h1);
        cfg(nhs_pkg::NHS_ADDR_RDIV, 32'h0);
        cfg(nhs_pkg::NHS_ADDR_CTRL, 32'h2);
        cfg(nhs_pkg::NHS_ADDR_CTRL, 32'hA);
        wr(nhs_pkg::NHS_HOST_LINK, 32'h0);
        repeat (10) @(posedge pclk);
        wr(nhs_pkg::NHS_HOST_LINK, 32'h1);
        repeat (10) @(posedge pclk);
        rd(nhs_pkg::NHS_HOST_STATUS, 33'h1);
        cfg(nhs_pkg::NHS_ADDR_CTRL, 32'h4);
        for (k = 0; k < 2; k++) begin
            wr(nhs_pkg::NHS_HOST_LINK, 32'h3);
            repeat (10) @(posedge pclk);
            wr(nhs_pkg::NHS_HOST_LINK, 32'h1);
            rd(nhs_pkg::NHS_HOST_STATUS, 33'h2);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
